// [verilog/icl_pkg.sv]
// Constants, state encoding and victim choice for the lockable instruction cache
package icl_pkg;

	localparam int CACHE_BYTES = 32768;
	localparam int ICL_WAYS    = 4;
	localparam int ICL_WORDS   = 8;
	localparam int ICL_WORD_W  = 32;
	localparam int ICL_LINE_BYTES = ICL_WORDS * ICL_WORD_W / 8;
	localparam int ICL_SETS    = CACHE_BYTES / (ICL_WAYS * ICL_LINE_BYTES);

	// Address field positions
	localparam int ICL_WORD_LSB = 2;
	localparam int ICL_IDX_LSB  = 5;
	localparam int ICL_VA_HI    = 12;
	localparam int ICL_TAG_LSB  = 12;
	localparam int ICL_PA_HI    = 35;

	localparam int ICL_WSEL_W = 3;
	localparam int ICL_IDX_W  = ICL_VA_HI - ICL_IDX_LSB + 1;
	localparam int ICL_TAG_W  = ICL_PA_HI - ICL_TAG_LSB + 1;
	localparam int ICL_WAY_W  = 2;
	localparam int ICL_RAM_AW = ICL_WAY_W + ICL_IDX_W + ICL_WSEL_W;
	localparam int ICL_LINE_AW = ICL_TAG_W + ICL_IDX_W;

	localparam logic [ICL_WSEL_W-1:0] ICL_LAST_WORD = 3'h7;
	localparam logic [ICL_WAY_W-1:0]  ICL_PTR_RST   = 2'h0;
	localparam logic [ICL_WORD_W-1:0] ICL_DATA_RST  = 32'h0000_0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FILL = 2'b10
	} icl_state_type;

	// Next way at or after ptr that is not a valid locked line; way 0 never locks
	function automatic logic [ICL_WAY_W-1:0] icl_pick_victim(
		input logic [ICL_WAY_W-1:0] ptr,
		input logic [ICL_WAYS-1:0]  pinned
	);
		logic [ICL_WAY_W-1:0] w;
		logic [ICL_WAY_W-1:0] res;
		res = ptr;
		for (int i = ICL_WAYS - 1; i >= 0; i--) begin
			w = ptr + ICL_WAY_W'(i);
			if (!pinned[w]) begin
				res = w;
			end
		end
		return res;
	endfunction

endpackage

// [verilog/icl_data_ram.sv]
// Instruction data store: one word port with registered read data
`timescale 1ns/1ps
module icl_data_ram
	import icl_pkg::*;
(
	input  wire logic                  ref_clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  rd_en_in,
	input  wire logic                  wr_en_in,
	input  wire logic [ICL_RAM_AW-1:0] addr_in,
	input  wire logic [ICL_WORD_W-1:0] wr_data_in,
	output logic      [ICL_WORD_W-1:0] rd_data_out
);

	// Four ways by 256 sets by 8 words of 32 bits: 32 KB
	logic [ICL_WORD_W-1:0] mem_q [0:(1 << ICL_RAM_AW) - 1];

	always_ff @(posedge ref_clk_in) begin
		if (wr_en_in) begin
			mem_q[addr_in] <= wr_data_in;
		end
	end

	// Read data hold until the next read so the fetch output stays stable
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= ICL_DATA_RST;
		end else if (rd_en_in) begin
			rd_data_out <= mem_q[addr_in];
		end
	end

endmodule // icl_data_ram

// [verilog/icl_cache.sv]
// Four-way lockable instruction cache with FIFO replacement and line refill
`timescale 1ns/1ps
module icl_cache
	import icl_pkg::*;
(
	input  wire logic                           ref_clk_in,
	input  wire logic                           rst_in,
	input  wire logic                           fetch_req_in,
	input  wire logic [ICL_VA_HI:ICL_WORD_LSB]  fetch_va_in,
	input  wire logic [ICL_TAG_W-1:0]           fetch_pa_tag_in,
	input  wire logic                           lock_enable_in,
	input  wire logic                           refill_valid_in,
	input  wire logic [ICL_WORD_W-1:0]          refill_data_in,
	output logic                                fetch_ready_out,
	output logic                                fetch_hit_out,
	output logic                                fetch_miss_out,
	output logic      [ICL_WORD_W-1:0]          fetch_data_out,
	output logic                                refill_req_out,
	output logic      [ICL_LINE_AW-1:0]         refill_addr_out
);

	// ************************************************************
	// Line state arrays
	// ************************************************************
	// Way 0 entry is {valid, tag}; ways 1-3 add a lock bit
	logic [ICL_TAG_W-1:0] tag_mem_q [0:ICL_WAYS-1][0:ICL_SETS-1];
	logic [ICL_WAYS-1:0]  valid_q   [0:ICL_SETS-1];
	logic [ICL_WAYS-1:1]  lock_q    [0:ICL_SETS-1];
	logic [ICL_WAY_W-1:0] repl_ptr_q [0:ICL_SETS-1];

	icl_state_type        state_q;
	logic [ICL_IDX_W-1:0] line_idx_q;
	logic [ICL_TAG_W-1:0] line_tag_q;
	logic [ICL_WAY_W-1:0] victim_q;
	logic                 lock_fill_q;
	logic [ICL_WSEL_W-1:0] word_cnt_q;
	logic                 ready_q;
	logic                 hit_q;
	logic                 miss_q;
	logic                 req_q;

	// ************************************************************
	// Lookup
	// ************************************************************
	wire logic [ICL_IDX_W-1:0]  look_idx  = fetch_va_in[ICL_VA_HI:ICL_IDX_LSB];
	wire logic [ICL_WSEL_W-1:0] look_word = fetch_va_in[ICL_IDX_LSB-1:ICL_WORD_LSB];
	wire logic                  take_req  = fetch_req_in && ready_q;
	wire logic                  fill_st   = (state_q == ST_FILL);

	logic [ICL_WAYS-1:0] hit_vec;
	for (genvar w = 0; w < ICL_WAYS; w++) begin : g_cmp
		// Physical tag compare on invalid lines is masked off
		assign hit_vec[w] = valid_q[look_idx][w] &&
			(tag_mem_q[w][look_idx] == fetch_pa_tag_in);
	end

	// Multiple hits are not expected; the lowest way wins if one occurs
	wire logic [ICL_WAY_W-1:0] hit_way = hit_vec[0] ? 2'h0 :
		hit_vec[1] ? 2'h1 :
		hit_vec[2] ? 2'h2 : 2'h3;
	wire logic look_hit = |hit_vec;

	// Valid locked lines are pinned and never chosen
	wire logic [ICL_WAYS-1:0] look_pinned =
		{lock_q[look_idx] & valid_q[look_idx][ICL_WAYS-1:1], 1'b0};
	wire logic [ICL_WAY_W-1:0] look_victim =
		icl_pick_victim(repl_ptr_q[look_idx], look_pinned);

	// ************************************************************
	// Refill
	// ************************************************************
	wire logic word_take = fill_st && refill_valid_in;
	wire logic last_word = word_take && (word_cnt_q == ICL_LAST_WORD);
	wire logic new_lock  = lock_fill_q && (victim_q != 2'h0);

	// Pinned set as it will stand once the filled line turns valid
	logic [ICL_WAYS-1:0] after_pinned;
	always_comb begin
		after_pinned = {lock_q[line_idx_q] & valid_q[line_idx_q][ICL_WAYS-1:1], 1'b0};
		after_pinned[victim_q] = new_lock;
	end

	// Pointer moves past the victim and skips ways that stay locked
	wire logic [ICL_WAY_W-1:0] next_ptr =
		icl_pick_victim(victim_q + 2'h1, after_pinned);

	wire logic [ICL_RAM_AW-1:0] ram_addr = fill_st ?
		{victim_q, line_idx_q, word_cnt_q} :
		{hit_way, look_idx, look_word};

	icl_data_ram u_ram (
		.ref_clk_in  (ref_clk_in),
		.rst_in      (rst_in),
		.rd_en_in    (take_req),
		.wr_en_in    (word_take),
		.addr_in     (ram_addr),
		.wr_data_in  (refill_data_in),
		.rd_data_out (fetch_data_out)
	);

	// ************************************************************
	// Control
	// ************************************************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			ready_q <= 1'b1;
			hit_q   <= 1'b0;
			miss_q  <= 1'b0;
			req_q   <= 1'b0;
		end else begin
			hit_q  <= take_req && look_hit;
			miss_q <= take_req && !look_hit;
			unique case (state_q)
				ST_IDLE: begin
					if (take_req && !look_hit) begin
						state_q <= ST_FILL;
						ready_q <= 1'b0;
						req_q   <= 1'b1;
					end
				end
				ST_FILL: begin
					if (last_word) begin
						state_q <= ST_IDLE;
						ready_q <= 1'b1;
						req_q   <= 1'b0;
					end
				end
			endcase
		end
	end

	// Miss context is captured once; the fetch side may change its inputs
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			line_idx_q  <= '0;
			line_tag_q  <= '0;
			victim_q    <= ICL_PTR_RST;
			lock_fill_q <= 1'b0;
		end else if (take_req && !look_hit) begin
			line_idx_q  <= look_idx;
			line_tag_q  <= fetch_pa_tag_in;
			victim_q    <= look_victim;
			lock_fill_q <= lock_enable_in;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			word_cnt_q <= '0;
		end else if (word_take) begin
			word_cnt_q <= word_cnt_q + 3'h1;
		end
	end

	// Line is written in word order, then turned valid in one step
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int s = 0; s < ICL_SETS; s++) begin
				valid_q[s]    <= '0;
				lock_q[s]     <= '0;
				repl_ptr_q[s] <= ICL_PTR_RST;
			end
		end else if (last_word) begin
			valid_q[line_idx_q][victim_q] <= 1'b1;
			if (victim_q != 2'h0) begin
				lock_q[line_idx_q][victim_q] <= new_lock;
			end
			repl_ptr_q[line_idx_q] <= next_ptr;
		end
	end

	// Tags need no reset: a cleared valid bit hides them
	always_ff @(posedge ref_clk_in) begin
		if (last_word) begin
			tag_mem_q[victim_q][line_idx_q] <= line_tag_q;
		end
	end

	assign fetch_ready_out = ready_q;
	assign fetch_hit_out   = hit_q;
	assign fetch_miss_out  = miss_q;
	assign refill_req_out  = req_q;
	assign refill_addr_out = {line_tag_q, line_idx_q};

endmodule // icl_cache

// [sim/icl_cache_asserts.sv]
// Port-level assertion checker for the lockable instruction cache
`timescale 1ns/1ps
module icl_cache_asserts
	import icl_pkg::*;
(
	input wire logic                          ref_clk_in,
	input wire logic                          rst_in,
	input wire logic                          fetch_req_in,
	input wire logic [ICL_VA_HI:ICL_WORD_LSB] fetch_va_in,
	input wire logic [ICL_TAG_W-1:0]          fetch_pa_tag_in,
	input wire logic                          refill_valid_in,
	input wire logic                          fetch_ready_out,
	input wire logic                          fetch_hit_out,
	input wire logic                          fetch_miss_out,
	input wire logic                          refill_req_out,
	input wire logic [ICL_LINE_AW-1:0]        refill_addr_out
);
	logic [3:0] words_q;
	logic [7:0] va_idx;
	assign va_idx = fetch_va_in[12:5];
	// Words taken in the current burst
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) words_q <= 4'h0;
		else if (!refill_req_out) words_q <= 4'h0;
		else if (refill_valid_in) words_q <= words_q + 4'h1;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	a_single_answer: assert property (fetch_req_in && fetch_ready_out |=> fetch_hit_out != fetch_miss_out)
		else $error("taken fetch without one answer");
	a_answer_cause: assert property (fetch_hit_out || fetch_miss_out |-> $past(fetch_req_in && fetch_ready_out))
		else $error("answer without a taken fetch");
	a_miss_starts_fill: assert property (fetch_miss_out |-> refill_req_out && !fetch_ready_out)
		else $error("miss did not start a refill");
	a_idle_no_fill: assert property (fetch_ready_out |-> !refill_req_out)
		else $error("ready during refill");
	a_miss_line_addr: assert property (fetch_req_in && fetch_ready_out ##1 fetch_miss_out |-> refill_addr_out == {$past(fetch_pa_tag_in), $past(va_idx)})
		else $error("wrong refill line address");
	a_addr_holds: assert property (refill_req_out && $past(refill_req_out) |-> $stable(refill_addr_out))
		else $error("refill address moved in burst");
	a_fill_done: assert property (refill_req_out && refill_valid_in && words_q == 4'h7 |=> !refill_req_out && fetch_ready_out)
		else $error("refill not ended after eight words");
	a_fill_length: assert property ($fell(refill_req_out) |-> $past(words_q) == 4'h7)
		else $error("refill ended early");
	a_reset_idle: assert property ($fell(rst_in) |-> fetch_ready_out && !refill_req_out)
		else $error("not idle after reset");
	c_hit: cover property (fetch_hit_out);
	c_miss: cover property (fetch_miss_out);
	c_fill_end: cover property ($fell(refill_req_out));
endmodule // icl_cache_asserts
bind icl_cache icl_cache_asserts u_icl_cache_asserts(.ref_clk_in, .rst_in, .fetch_req_in,
	.fetch_va_in, .fetch_pa_tag_in, .refill_valid_in, .fetch_ready_out, .fetch_hit_out,
	.fetch_miss_out, .refill_req_out, .refill_addr_out);

// [sim/icl_mem_model.sv]
// Main memory model that answers line refill bursts, promptly or with gaps
`timescale 1ns/1ps
module icl_mem_model (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        req_in,
	input  wire logic [31:0] addr_in,
	input  wire logic        slow_in,
	output logic             valid_out,
	output logic      [31:0] data_out
);
	logic [3:0] n;
	logic       nv;
	logic       gap_q;
	logic [2:0] cnt_q;
	// Words taken so far, counting the one the cache takes at this edge
	assign n  = {1'b0, cnt_q} + {3'h0, req_in && valid_out};
	assign nv = req_in && n < 4'h8 && !(slow_in && !gap_q);
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= 3'h0;
			gap_q <= 1'b0;
			valid_out <= 1'b0;
			data_out <= 32'h0;
		end else begin
			gap_q <= ~gap_q;
			cnt_q <= n[2:0];
			valid_out <= nv;
			// Words in ascending order; idle lines invert the previous value every cycle
			data_out <= nv ? {addr_in[28:0], n[2:0]} : ~data_out;
		end
	end
endmodule // icl_mem_model

// [sim/testbench.sv]
// Self-checking bench for the lockable instruction cache
`timescale 1ns/1ps
module testbench;
	import icl_pkg::*;
	logic        clk, rst, req, lock, slow, rv, hit, miss, rdy, rreq;
	logic [10:0] va;
	logic [23:0] pa, tg;
	logic [31:0] rd, fd, ra, seed;
	logic [7:0]  ix;
	int          n_fail, num_checks;
	icl_cache u_icl_cache(.ref_clk_in(clk), .rst_in(rst), .fetch_req_in(req), .fetch_va_in(va),
		.fetch_pa_tag_in(pa), .lock_enable_in(lock), .refill_valid_in(rv), .refill_data_in(rd),
		.fetch_ready_out(rdy), .fetch_hit_out(hit), .fetch_miss_out(miss), .fetch_data_out(fd),
		.refill_req_out(rreq), .refill_addr_out(ra));
	icl_mem_model u_icl_mem_model(.clk_in(clk), .rst_in(rst), .req_in(rreq), .addr_in(ra),
		.slow_in(slow), .valid_out(rv), .data_out(rd));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
	endtask
	// One fetch; on a miss wait out the refill
	task automatic acc(input logic [7:0] i, input logic [23:0] t, input logic eh);
		logic [23:0] p;
		logic [2:0]  w;
		p = {t[23:1], i[7]};
		seed = nxt(seed);
		w = seed[2:0];
		@(posedge clk);
		req <= 1'b1;
		va <= {i, w};
		pa <= p;
		slow <= seed[8];
		@(posedge clk);
		req <= 1'b0;
		#1;
		chk(hit, eh, "hit flag");
		chk(miss, !eh, "miss flag");
		if (eh) chk(fd, {p[20:0], i, w}, "fetched word");
		else begin
			chk(ra, {p, i}, "refill address");
			chk(rdy, 1'b0, "ready during refill");
			for (int k = 0; k < 40 && !rdy; k++) @(posedge clk) #1;
			chk(rdy, 1'b1, "refill end");
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (10000) @(posedge clk);
		n_fail++;
		results();
	end
	initial begin
		{rst, req, lock, slow, va, pa} = '0;
		seed = 32'hF9E5;
		do_reset();
		// Random lines: first touch misses, second hits
		for (int t = 0; t < 6; t++) begin
			seed = nxt(seed);
			ix = seed[15:8];
			tg = seed[31:8];
			acc(ix, tg, 1'b0);
			acc(ix, tg, 1'b1);
		end
		$display("test random done");
		do_reset();
		acc(ix, tg, 1'b0);
		// Fifth tag in a set evicts the oldest way
		for (int k = 0; k < 5; k++) acc(8'h10, {8'(k), 16'h0}, 1'b0);
		acc(8'h10, 24'h010000, 1'b1);
		acc(8'h10, 24'h000000, 1'b0);
		$display("test fifo done");
		@(posedge clk);
		lock <= 1'b1;
		for (int k = 0; k < 4; k++) acc(8'h90, {8'(k), 16'h0}, 1'b0);
		@(posedge clk);
		lock <= 1'b0;
		acc(8'h90, 24'h040000, 1'b0);
		acc(8'h90, 24'h050000, 1'b0);
		for (int k = 1; k < 4; k++) acc(8'h90, {8'(k), 16'h0}, 1'b1);
		acc(8'h90, 24'h040000, 1'b0);
		$display("test lock done");
		results();
	end
endmodule // testbench
